// File: sfp_pkg.sv
// Operation
// - Each state machine has a write-only transmit port; each bus write enqueues one word.
// - A write to a full transmit queue leaves it unchanged and sets its sticky overflow flag.
// - Each state machine has a read-only receive port; each bus read dequeues one word.
// - A read of an empty receive queue leaves it unchanged and sets its sticky underflow flag.
// - Two identical copies of the register block are decoded, at 0x50200000 and 0x50300000.
// - Control sits at 0x000, queue status at 0x004, error flags at 0x008, levels at 0x00c.
package sfp_pkg;
  // Sizes of the block
  localparam int NUM_SM = 4;
  localparam int NUM_INST = 2;
  localparam int NUM_QSIDE = 8;
  localparam int NUM_Q = 16;
  localparam int DEPTH = 4;
  localparam int PTR_W = 2;
  localparam int CNT_W = 3;

  // Instance decode
  localparam logic [31:0] FIRST_INSTANCE_BASE = 32'h5020_0000;
  localparam logic [31:0] SECOND_INSTANCE_BASE = 32'h5030_0000;
  localparam logic [31:0] INSTANCE_SPAN_MASK = 32'h0000_0FFF;

  // Register offsets
  localparam logic [11:0] OFS_BLOCK_CONTROL = 12'h000;
  localparam logic [11:0] OFS_QUEUE_STATUS = 12'h004;
  localparam logic [11:0] OFS_QUEUE_ERROR_FLAGS = 12'h008;
  localparam logic [11:0] OFS_QUEUE_LEVELS = 12'h00C;
  localparam logic [11:0] OFS_TX_PORT_SM0 = 12'h010;
  localparam logic [11:0] OFS_TX_PORT_SM3 = 12'h01C;
  localparam logic [11:0] OFS_RX_PORT_SM0 = 12'h020;
  localparam logic [11:0] OFS_RX_PORT_SM1 = 12'h024;
  localparam logic [11:0] OFS_RX_PORT_SM2 = 12'h028;
  localparam logic [11:0] OFS_RX_PORT_SM3 = 12'h02C;

  // Field positions
  localparam int CTRL_ENABLE_LSB = 0;
  localparam int STAT_RX_FULL_LSB = 0;
  localparam int STAT_RX_EMPTY_LSB = 8;
  localparam int STAT_TX_FULL_LSB = 16;
  localparam int STAT_TX_EMPTY_LSB = 24;
  localparam int ERR_RX_UNDERFLOW_LSB = 16;
  localparam int ERR_TX_OVERFLOW_LSB = 24;
  localparam int LEVEL_TX_LSB = 0;
  localparam int LEVEL_RX_LSB = 4;
  localparam int LEVEL_STRIDE = 8;
  localparam int LEVEL_W = 4;

  // Reset values
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [7:0] ERR_RESET = 8'h00;

  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

// File: sfp_top.sv
`timescale 1ns/1ns
module sfp_top
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [sfp_pkg::NUM_QSIDE-1:0] sm_enable,
  input wire logic [sfp_pkg::NUM_QSIDE-1:0] sm_tx_pull,
  output logic [sfp_pkg::NUM_QSIDE-1:0] sm_tx_valid,
  output logic [sfp_pkg::NUM_QSIDE-1:0][31:0] sm_tx_word,
  input wire logic [sfp_pkg::NUM_QSIDE-1:0] sm_rx_push,
  input wire logic [sfp_pkg::NUM_QSIDE-1:0][31:0] sm_rx_word
);
  import sfp_pkg::*;

  logic [31:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic [31:0] ar_addr_q;
  logic do_write;
  logic do_read;
  logic w_hit;
  logic w_inst;
  logic [11:0] w_word;
  logic r_hit;
  logic r_inst;
  logic [11:0] r_word;
  logic w_tx_port;
  logic r_rx_port;
  logic err_wr;
  logic [31:0] next_rdata;
  logic [NUM_Q-1:0] q_push;
  logic [NUM_Q-1:0] q_pop;
  logic [NUM_Q-1:0] q_full;
  logic [NUM_Q-1:0] q_empty;
  logic [31:0] q_in [NUM_Q];
  logic [31:0] q_head [NUM_Q];
  logic [CNT_W-1:0] q_cnt [NUM_Q];
  logic [NUM_QSIDE-1:0] tx_overflow_sticky;
  logic [NUM_QSIDE-1:0] rx_underflow_sticky;
  logic [NUM_QSIDE-1:0] clr_tx;
  logic [NUM_QSIDE-1:0] clr_rx;

  // Held request moves once both halves are in and no answer waits
  assign do_write = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  assign do_read = ~s_axi_arready & ~s_axi_rvalid;

  assign w_hit = ((aw_addr_q & ~INSTANCE_SPAN_MASK) == FIRST_INSTANCE_BASE)
    || ((aw_addr_q & ~INSTANCE_SPAN_MASK) == SECOND_INSTANCE_BASE);
  assign w_inst = (aw_addr_q & ~INSTANCE_SPAN_MASK) == SECOND_INSTANCE_BASE;
  assign r_hit = ((ar_addr_q & ~INSTANCE_SPAN_MASK) == FIRST_INSTANCE_BASE)
    || ((ar_addr_q & ~INSTANCE_SPAN_MASK) == SECOND_INSTANCE_BASE);
  assign r_inst = (ar_addr_q & ~INSTANCE_SPAN_MASK) == SECOND_INSTANCE_BASE;

  // Word-aligned offsets inside an instance
  assign w_word = {aw_addr_q[11:2], 2'b00};
  assign r_word = {ar_addr_q[11:2], 2'b00};
  assign w_tx_port = w_hit && (w_word[11:4] == OFS_TX_PORT_SM0[11:4]);
  // all four receive ports in one word row
  assign r_rx_port = r_hit && (r_word[11:4] == OFS_RX_PORT_SM0[11:4]);
  assign err_wr = do_write && w_hit && (w_word == OFS_QUEUE_ERROR_FLAGS);

  // Write address and data channels, then the response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      aw_addr_q <= 32'h0000_0000;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= w_hit ? RESP_OKAY : RESP_DECERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Read address channel, then the data answer
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      ar_addr_q <= 32'h0000_0000;
    end
    else
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        ar_addr_q <= s_axi_araddr;
        s_axi_arready <= 1'b0;
      end
      if (do_read)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= next_rdata;
        s_axi_rresp <= r_hit ? RESP_OKAY : RESP_DECERR;
      end
      if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Read data selection
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (r_hit)
    begin
      case (r_word)
        OFS_BLOCK_CONTROL:
          next_rdata[CTRL_ENABLE_LSB +: NUM_SM] = r_inst ? sm_enable[7:4] : sm_enable[3:0];
        OFS_QUEUE_STATUS:
          for (int i = 0; i < NUM_SM; i++)
          begin
            next_rdata[STAT_RX_FULL_LSB + i] = q_full[{1'b1, r_inst, 2'(i)}];
            next_rdata[STAT_RX_EMPTY_LSB + i] = q_empty[{1'b1, r_inst, 2'(i)}];
            next_rdata[STAT_TX_FULL_LSB + i] = q_full[{1'b0, r_inst, 2'(i)}];
            next_rdata[STAT_TX_EMPTY_LSB + i] = q_empty[{1'b0, r_inst, 2'(i)}];
          end
        OFS_QUEUE_ERROR_FLAGS:
          for (int i = 0; i < NUM_SM; i++)
          begin
            next_rdata[ERR_RX_UNDERFLOW_LSB + i] = rx_underflow_sticky[{r_inst, 2'(i)}];
            next_rdata[ERR_TX_OVERFLOW_LSB + i] = tx_overflow_sticky[{r_inst, 2'(i)}];
          end
        OFS_QUEUE_LEVELS:
          for (int i = 0; i < NUM_SM; i++)
          begin
            next_rdata[LEVEL_STRIDE * i + LEVEL_TX_LSB +: LEVEL_W] =
              {1'b0, q_cnt[{1'b0, r_inst, 2'(i)}]};
            next_rdata[LEVEL_STRIDE * i + LEVEL_RX_LSB +: LEVEL_W] =
              {1'b0, q_cnt[{1'b1, r_inst, 2'(i)}]};
          end
        // empty queue returns a stale word
        OFS_RX_PORT_SM0, OFS_RX_PORT_SM1, OFS_RX_PORT_SM2, OFS_RX_PORT_SM3:
          next_rdata = q_head[{1'b1, r_inst, r_word[3:2]}];
        default:
          next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // Queue requests from the bus and from the state machines
  always_comb
  begin
    q_push = '0;
    q_pop = '0;
    for (int i = 0; i < NUM_QSIDE; i++)
    begin
      q_push[NUM_QSIDE + i] = sm_rx_push[i] & sm_enable[i];
      q_pop[i] = sm_tx_pull[i] & sm_enable[i];
    end
    if (do_write && w_tx_port)
      q_push[{1'b0, w_inst, w_word[3:2]}] = 1'b1;
    if (do_read && r_rx_port)
      q_pop[{1'b1, r_inst, r_word[3:2]}] = 1'b1;
  end

  // Queue input words
  always_comb
  begin
    for (int i = 0; i < NUM_QSIDE; i++)
    begin
      q_in[i] = w_data_q;
      q_in[NUM_QSIDE + i] = sm_rx_word[i];
    end
  end

  // Transmit and receive queues, one per state machine and direction
  for (genvar g = 0; g < NUM_Q; g++)
  begin : g_queue
    logic [31:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic do_push;
    logic do_pop;

    assign do_push = q_push[g] & ~q_full[g];
    assign do_pop = q_pop[g] & ~q_empty[g];
    assign q_full[g] = q_cnt[g] == CNT_W'(DEPTH);
    assign q_empty[g] = q_cnt[g] == '0;
    assign q_head[g] = mem[rd_ptr];

    // Storage
    always_ff @(posedge aclk)
    begin
      if (do_push)
        mem[wr_ptr] <= q_in[g];
    end

    // Pointers and fill count
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        wr_ptr <= '0;
        rd_ptr <= '0;
        q_cnt[g] <= '0;
      end
      else
      begin
        if (do_push)
          wr_ptr <= wr_ptr + 2'h1;
        if (do_pop)
          rd_ptr <= rd_ptr + 2'h1;
        case ({do_push, do_pop})
          2'b10: q_cnt[g] <= q_cnt[g] + 3'h1;
          2'b01: q_cnt[g] <= q_cnt[g] - 3'h1;
          default: q_cnt[g] <= q_cnt[g];
        endcase
      end
    end
  end

  // State-machine side of the transmit queues
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sm_tx_valid <= '0;
      sm_tx_word <= '0;
    end
    else
    begin
      for (int i = 0; i < NUM_QSIDE; i++)
      begin
        sm_tx_valid[i] <= q_pop[i] & ~q_empty[i];
        sm_tx_word[i] <= q_head[i];
      end
    end
  end

  // Control register, one enable nibble per instance
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      sm_enable <= {CTRL_RESET, CTRL_RESET};
    else if (do_write && w_hit && (w_word == OFS_BLOCK_CONTROL) && w_strb_q[0])
    begin
      if (w_inst)
        sm_enable[7:4] <= w_data_q[CTRL_ENABLE_LSB +: NUM_SM];
      else
        sm_enable[3:0] <= w_data_q[CTRL_ENABLE_LSB +: NUM_SM];
    end
  end

  // Write-one-to-clear masks for the error flags
  always_comb
  begin
    for (int i = 0; i < NUM_QSIDE; i++)
    begin
      clr_tx[i] = err_wr && (w_inst == i[2]) && w_strb_q[3]
        && w_data_q[ERR_TX_OVERFLOW_LSB + i % NUM_SM];
      clr_rx[i] = err_wr && (w_inst == i[2]) && w_strb_q[2]
        && w_data_q[ERR_RX_UNDERFLOW_LSB + i % NUM_SM];
    end
  end

  // Sticky error flags, a new event beats a clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_overflow_sticky <= ERR_RESET;
      rx_underflow_sticky <= ERR_RESET;
    end
    else
    begin
      for (int i = 0; i < NUM_QSIDE; i++)
      begin
        tx_overflow_sticky[i] <= (tx_overflow_sticky[i] & ~clr_tx[i]) | (q_push[i] & q_full[i]);
        rx_underflow_sticky[i] <= (rx_underflow_sticky[i] & ~clr_rx[i])
          | (q_pop[NUM_QSIDE + i] & q_empty[NUM_QSIDE + i]);
      end
    end
  end

  // Checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_tx0_write;
    do_write && w_tx_port && !w_inst && (w_word == OFS_TX_PORT_SM0) && !q_pop[0];
  endsequence

  sequence s_rx0_read;
    do_read && r_rx_port && !r_inst && (r_word == OFS_RX_PORT_SM0) && !q_push[8];
  endsequence

  sequence s_both_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence

  a_tx_push_one: assert property (
    s_tx0_write ##0 !q_full[0] |=> (q_cnt[0] == $past(q_cnt[0]) + 3'h1) && !tx_overflow_sticky[0]
      || $past(tx_overflow_sticky[0]))
    else $error("transmit port write did not add exactly one word");

  a_tx_full_hold: assert property (
    s_tx0_write ##0 q_full[0] |=> q_full[0] && tx_overflow_sticky[0]
      && $stable(g_queue[0].wr_ptr))
    else $error("write to full transmit queue changed it or left no flag");

  a_rx_pop_one: assert property (
    s_rx0_read ##0 !q_empty[8] |=> s_axi_rvalid && (s_axi_rdata == $past(q_head[8]))
      && (q_cnt[8] == $past(q_cnt[8]) - 3'h1))
    else $error("receive port read did not pop one word");

  a_rx_under_flag: assert property (
    s_rx0_read ##0 q_empty[8] |=> rx_underflow_sticky[0] && q_empty[8] && s_axi_rvalid
      && (s_axi_rresp == RESP_OKAY))
    else $error("read of empty receive queue not flagged or queue changed");

  a_base_decode: assert property (
    s_axi_arvalid && s_axi_arready |=> ##1 s_axi_rvalid && (s_axi_rresp == (
      (($past(s_axi_araddr, 2) & ~INSTANCE_SPAN_MASK) == FIRST_INSTANCE_BASE)
      || (($past(s_axi_araddr, 2) & ~INSTANCE_SPAN_MASK) == SECOND_INSTANCE_BASE)
      ? RESP_OKAY : RESP_DECERR)))
    else $error("instance window decode answered wrongly");

  a_status_map: assert property (
    do_read && r_hit && !r_inst && (r_word == OFS_QUEUE_STATUS)
      |=> (s_axi_rdata[STAT_RX_EMPTY_LSB] == $past(q_empty[8]))
      && (s_axi_rdata[STAT_TX_FULL_LSB] == $past(q_full[0])))
    else $error("queue status word does not match the queues");

  a_rx_port_sm3: assert property (
    do_read && r_hit && r_inst && (r_word == OFS_RX_PORT_SM3) && !q_empty[15] && !q_push[15]
      |=> q_cnt[15] == $past(q_cnt[15]) - 3'h1)
    else $error("fourth receive port did not pop its own queue");

  a_write_answer: assert property (
    s_both_taken |=> ##1 s_axi_bvalid)
    else $error("write response not raised two cycles after handshake");
endmodule

// File: sfp_sm_model.sv
`timescale 1ns/1ns
module sfp_sm_model
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [sfp_pkg::NUM_QSIDE-1:0] pull_cmd,
  input wire logic [sfp_pkg::NUM_QSIDE-1:0] push_cmd,
  input wire logic [31:0] push_val,
  input wire logic [sfp_pkg::NUM_QSIDE-1:0] sm_tx_valid,
  input wire logic [sfp_pkg::NUM_QSIDE-1:0][31:0] sm_tx_word,
  output logic [sfp_pkg::NUM_QSIDE-1:0] sm_tx_pull,
  output logic [sfp_pkg::NUM_QSIDE-1:0] sm_rx_push,
  output logic [sfp_pkg::NUM_QSIDE-1:0][31:0] sm_rx_word,
  output logic [31:0] got_word,
  output logic [7:0] got_n
);
  import sfp_pkg::*;
  // Requests follow the bench commands
  assign sm_tx_pull = pull_cmd;
  assign sm_rx_push = push_cmd;
  // Lanes carry the word only while pushing, its inverse otherwise
  always_comb
  begin
    for (int i = 0; i < NUM_QSIDE; i++)
      sm_rx_word[i] = push_cmd[i] ? push_val : ~push_val;
  end
  // Capture the popped word of the highest pulsing lane and count the cycles with a pulse
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      got_n <= 8'h00;
      got_word <= 32'h0000_0000;
    end
    else
      for (int i = 0; i < NUM_QSIDE; i++)
        if (sm_tx_valid[i])
        begin
          got_word <= sm_tx_word[i];
          got_n <= got_n + 8'h01;
        end
  end
endmodule

// File: tb_state_machine_fifo_port.sv
`timescale 1ns/1ns
module tb_state_machine_fifo_port;
  import sfp_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, push_val = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] pull_cmd = 8'h00, push_cmd = 8'h00, got_n, tx_valid, tx_pull, rx_push, en;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, got_word, d;
  logic [7:0][31:0] tx_word, rx_word;
  logic [31:0] w [4];
  int err_count = 0, n_checks = 0, q, k, sm, inst;

  sfp_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .sm_enable(en), .sm_tx_pull(tx_pull), .sm_tx_valid(tx_valid),
    .sm_tx_word(tx_word), .sm_rx_push(rx_push), .sm_rx_word(rx_word));
  sfp_sm_model sm_u (.aclk(aclk), .aresetn(aresetn), .pull_cmd(pull_cmd), .push_cmd(push_cmd),
    .push_val(push_val), .sm_tx_valid(tx_valid), .sm_tx_word(tx_word), .sm_tx_pull(tx_pull),
    .sm_rx_push(rx_push), .sm_rx_word(rx_word), .got_word(got_word), .got_n(got_n));

  // Free-running bus clock
  always #5 aclk = ~aclk;

  // Byte address of a register in one instance
  function automatic logic [31:0] adr(input int i, input int o);
    return (i != 0 ? SECOND_INSTANCE_BASE : FIRST_INSTANCE_BASE) | 32'(o);
  endfunction
  // Expected level field of one state machine
  function automatic logic [31:0] lvl(input int s, input int tx, input int rx);
    return 32'((rx * 16 + tx) << (s * 8));
  endfunction

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic fail(input string m);
    err_count++;
    $display("[FAIL] %0t %s", $time, m);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    n_checks++;
    if (g !== e)
      fail(m);
  endtask
  task automatic hang();
    fail("wait timed out");
    wrap_up();
  endtask

  // Write cycle: address and data together, each released when taken
  task automatic wr(input logic [31:0] a, input logic [31:0] v, output logic [1:0] rs);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 64; n++)
    begin
      @(posedge aclk);
      // Released payload shows its inverse
      if (awvalid && awready)
      begin
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (wvalid && wready)
      begin
        wvalid <= 1'b0;
        wdata <= ~v;
      end
      if (bvalid && bready)
      begin
        rs = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (n == 64) hang();
  endtask
  // Read cycle
  task automatic rd(input logic [31:0] a, output logic [31:0] v, output logic [1:0] rs);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 64; n++)
    begin
      @(posedge aclk);
      // Released address shows its inverse
      if (arvalid && arready)
      begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
      if (rvalid && rready)
      begin
        v = rdata;
        rs = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (n == 64) hang();
  endtask
  // One state-machine side pop, waiting for its pulse
  task automatic pull_one(input int qi);
    int n;
    logic [7:0] n0;
    n0 = got_n;
    @(posedge aclk);
    pull_cmd <= 8'(1 << qi);
    @(posedge aclk);
    pull_cmd <= 8'h00;
    for (n = 0; n < 8; n++)
    begin
      @(posedge aclk);
      if (got_n != n0) break;
    end
    if (n == 8) hang();
  endtask
  // One state-machine side push
  task automatic push_one(input int qi, input logic [31:0] v);
    @(posedge aclk);
    push_cmd <= 8'(1 << qi);
    push_val <= v;
    @(posedge aclk);
    push_cmd <= 8'h00;
  endtask

  initial
  begin
    void'($urandom(17085));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    // Register map and reset values in both instances
    for (inst = 0; inst < 2; inst++)
    begin
      rd(adr(inst, OFS_BLOCK_CONTROL), d, r);
      chk(d, 32'h0, "control reset");
      rd(adr(inst, OFS_QUEUE_STATUS), d, r);
      chk(d, 32'h0F00_0F00, "status reset");
      rd(adr(inst, OFS_QUEUE_ERROR_FLAGS), d, r);
      chk(d, 32'h0, "flags reset");
      rd(adr(inst, OFS_QUEUE_LEVELS), d, r);
      chk(d, 32'h0, "levels reset");
      wr(adr(inst, OFS_BLOCK_CONTROL), 32'h0000_000F, r);
      chk(32'(r), 32'(RESP_OKAY), "control write answer");
      rd(adr(inst, OFS_BLOCK_CONTROL), d, r);
      chk(d, 32'h0000_000F, "control write");
      chk(32'(en), (inst != 0) ? 32'h0000_00FF : 32'h0000_000F, "enable lanes");
      rd(adr(inst, 12'h030), d, r);
      chk(d, 32'h0, "unused offset data");
      chk(32'(r), 32'(RESP_OKAY), "unused offset answer");
    end
    rd(32'h5040_0004, d, r);
    chk(32'(r), 32'(RESP_DECERR), "read outside windows");
    wr(32'h5010_0010, 32'h1234_5678, r);
    chk(32'(r), 32'(RESP_DECERR), "write outside windows");
    $display("test map done");
    // Transmit ports: fill, overflow, drain in order
    for (q = 0; q < 8; q++)
    begin
      inst = q / 4;
      sm = q % 4;
      for (k = 0; k < 4; k++)
      begin
        w[k] = $urandom;
        wr(adr(inst, OFS_TX_PORT_SM0 + 4 * sm), w[k], r);
      end
      rd(adr(inst, OFS_QUEUE_LEVELS), d, r);
      chk(d, lvl(sm, 4, 0), "tx level after fill");
      wr(adr(inst, OFS_TX_PORT_SM0 + 4 * sm), $urandom, r);
      chk(32'(r), 32'(RESP_OKAY), "overflow write answer");
      rd(adr(inst, OFS_QUEUE_ERROR_FLAGS), d, r);
      chk(d, 32'h1 << (ERR_TX_OVERFLOW_LSB + sm), "overflow flag");
      rd(adr(inst, OFS_QUEUE_LEVELS), d, r);
      chk(d, lvl(sm, 4, 0), "tx level after overflow");
      for (k = 0; k < 4; k++)
      begin
        pull_one(q);
        chk(got_word, w[k], "tx word order");
      end
      rd(adr(inst, OFS_QUEUE_LEVELS), d, r);
      chk(d, 32'h0, "tx level after drain");
      wr(adr(inst, OFS_QUEUE_ERROR_FLAGS), 32'hFFFF_FFFF, r);
      rd(adr(inst, OFS_QUEUE_ERROR_FLAGS), d, r);
      chk(d, 32'h0, "overflow flag cleared");
    end
    $display("test transmit done");
    // Receive ports: fill from the far side, drain, underflow
    for (q = 0; q < 8; q++)
    begin
      inst = q / 4;
      sm = q % 4;
      for (k = 0; k < 4; k++)
      begin
        w[k] = $urandom;
        push_one(q, w[k]);
      end
      rd(adr(inst, OFS_QUEUE_STATUS), d, r);
      chk(d, 32'h0F00_0F00 ^ (32'h101 << sm), "rx full status");
      for (k = 0; k < 4; k++)
      begin
        rd(adr(inst, OFS_RX_PORT_SM0 + 4 * sm), d, r);
        chk(d, w[k], "rx word order");
      end
      // Empty read: only the answer is compared
      rd(adr(inst, OFS_RX_PORT_SM0 + 4 * sm), d, r);
      chk(32'(r), 32'(RESP_OKAY), "empty read answer");
      rd(adr(inst, OFS_QUEUE_ERROR_FLAGS), d, r);
      chk(d, 32'h1 << (ERR_RX_UNDERFLOW_LSB + sm), "underflow flag");
      rd(adr(inst, OFS_QUEUE_LEVELS), d, r);
      chk(d, 32'h0, "levels after underflow");
      wr(adr(inst, OFS_QUEUE_ERROR_FLAGS), 32'hFFFF_FFFF, r);
    end
    $display("test receive done");
    wrap_up();
  end
endmodule
